//--- verilog/ptp_corr_pkg.sv
// Constants and types for the timestamp correction register block.
// Assumes a single 20 MHz clock domain and synchronous inputs.
package ptp_corr_pkg;

  // ----------------------------------------
  // MAC register offsets and fields
  // ----------------------------------------
  localparam logic [11:0] RX_CFG1_OFS = 12'h404;
  localparam logic [11:0] TX_ADJ_OFS = 12'h41C;
  localparam logic [31:0] RX_CFG1_RST = 32'h1000_0000;
  localparam logic [31:0] RX_CFG1_WMASK = 32'hFF40_FFFF;
  localparam int RX_INLINE_BIT = 22;
  localparam int PAUSE_SA_MSB = 15;
  localparam logic [31:0] TX_ADJ_RST = 32'h0000_00D8;
  localparam logic [31:0] TX_ADJ_WMASK = 32'h0001_FFFF;
  localparam int TX_CORR_EN_BIT = 16;
  localparam int TX_LAT_MSB = 15;

  // ----------------------------------------
  // PCS management registers
  // ----------------------------------------
  localparam logic [4:0] RXC_ADDR = 5'h13;
  localparam logic [4:0] RX_FIXED_ADDR = 5'h14;
  localparam logic [4:0] RX_VAR_ADDR = 5'h15;
  localparam logic [15:0] RXC_RST = 16'h000D;
  localparam logic [15:0] RXC_WMASK = 16'h000D;
  localparam int RXC_MASTER_BIT = 3;
  localparam int RXC_FIXED_BIT = 2;
  localparam int RXC_VAR_BIT = 0;
  localparam logic [15:0] RX_FIXED_RST = 16'h00C8;

  // ----------------------------------------
  // Unit interval to nanoseconds: 0.8 ns = 4/5
  // ----------------------------------------
  localparam int UI_NUM_SHIFT = 2;
  localparam logic [17:0] UI_DEN = 18'h00005;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic [63:0] ns;
  } ts_t;

  typedef struct packed {
    logic tx_en;
    logic [15:0] tx_lat_ns;
    logic rx_master;
    logic rx_fixed_en;
    logic rx_var_en;
    logic [15:0] rx_fixed_ns;
    logic [15:0] rx_var_ui;
  } corr_ctrl_t;

endpackage

//--- verilog/ts_corrector.sv
// Timestamp latency corrector: adds Tx latency, subtracts enabled Rx latencies.
// Assumes control words are stable while timestamps pass.
`timescale 1ns/1ns
module ts_corrector
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Control
  input wire ptp_corr_pkg::corr_ctrl_t ctrl,
  // Timestamps in
  input wire ptp_corr_pkg::ts_t tx_in,
  input wire ptp_corr_pkg::ts_t rx_in,
  // Timestamps out
  output ptp_corr_pkg::ts_t tx_out,
  output ptp_corr_pkg::ts_t rx_out
);

  logic [17:0] var_scaled;
  logic [15:0] var_ns;
  logic [63:0] tx_add;
  logic [63:0] rx_sub;
  logic [16:0] rx_sum;
  ptp_corr_pkg::ts_t tx_reg;
  ptp_corr_pkg::ts_t rx_reg;

  // ----------------------------------------
  // Correction terms
  // ----------------------------------------
  // Division by a constant keeps the UI scale exact at the cost of some logic
  assign var_scaled = 18'(ctrl.rx_var_ui) << ptp_corr_pkg::UI_NUM_SHIFT;
  assign var_ns = 16'((var_scaled / ptp_corr_pkg::UI_DEN));
  assign tx_add = ctrl.tx_en ? {48'h0, ctrl.tx_lat_ns} : 64'h0;
  assign rx_sum = (ctrl.rx_fixed_en ? {1'b0, ctrl.rx_fixed_ns} : 17'h0)
                + (ctrl.rx_var_en ? {1'b0, var_ns} : 17'h0);
  assign rx_sub = ctrl.rx_master ? {47'h0, rx_sum} : 64'h0;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_reg <= '0;
      rx_reg <= '0;
    end
    else
    begin
      tx_reg <= '{valid: tx_in.valid, ns: tx_in.ns + tx_add};
      rx_reg <= '{valid: rx_in.valid, ns: rx_in.ns - rx_sub};
    end
  end

  assign tx_out = tx_reg;
  assign rx_out = rx_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_TX_ADJUSTED: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tx_in.valid && ctrl.tx_en |=> tx_out.ns == $past(tx_in.ns) + {48'h0, $past(ctrl.tx_lat_ns)})
    else $error("Tx timestamp not advanced by latency");
  AST_TX_RAW: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tx_in.valid && !ctrl.tx_en |=> tx_out.valid && tx_out.ns == $past(tx_in.ns))
    else $error("Tx timestamp altered while correction off");
  AST_RX_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rx_in.valid && !ctrl.rx_master |=> rx_out.ns == $past(rx_in.ns))
    else $error("Rx timestamp altered while master enable off");
  AST_RX_FIXED: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rx_in.valid && ctrl.rx_master && ctrl.rx_fixed_en && !ctrl.rx_var_en
    |=> rx_out.ns == $past(rx_in.ns) - {48'h0, $past(ctrl.rx_fixed_ns)})
    else $error("Rx fixed latency not subtracted");

endmodule // ts_corrector

//--- verilog/ptp_timestamp_correction_regs.sv
// Timestamp correction registers: MAC config words and PCS management registers.
// Assumes synchronous single-cycle read and write strobes on both ports.
`timescale 1ns/1ns
module ptp_timestamp_correction_regs
#(
  parameter bit PTP_EN = 1'b1,
  parameter bit PCS_1000X = 1'b1
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // MAC configuration port
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [11:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  // PCS management port
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [4:0] mgmt_addr,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata,
  output logic mgmt_rvalid,
  // Receive lock and deserializer position
  input wire logic rx_sync_ok,
  input wire logic [15:0] barrel_pos,
  // Configuration outputs
  output logic [31:0] rx_cfg_word,
  output logic [15:0] pause_sa_hi,
  output logic rx_inline_ts_en,
  // Timestamps
  input wire ptp_corr_pkg::ts_t tx_ts_in,
  input wire ptp_corr_pkg::ts_t rx_ts_in,
  output ptp_corr_pkg::ts_t tx_ts_out,
  output ptp_corr_pkg::ts_t rx_ts_out
);

  logic [31:0] rx_cfg1_reg;
  logic [31:0] rx_cfg1_next;
  logic rx_inline_reg;
  logic [31:0] tx_adj_reg;
  logic [31:0] tx_adj_next;
  logic [15:0] rxc_reg;
  logic [15:0] rxc_next;
  logic [15:0] rx_fixed_reg;
  logic [15:0] rx_fixed_next;
  logic [15:0] var_ui_reg;
  logic sync_q_reg;
  logic [31:0] cfg_rdata_reg;
  logic cfg_rvalid_reg;
  logic [15:0] mgmt_rdata_reg;
  logic mgmt_rvalid_reg;
  logic [31:0] cfg_rmux;
  logic [15:0] mgmt_rmux;
  wire logic hit_rx_cfg1;
  wire logic hit_tx_adj;
  wire logic hit_rxc;
  wire logic hit_fixed;
  wire logic hit_var;
  wire logic sync_rise;
  ptp_corr_pkg::corr_ctrl_t ctrl;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  assign hit_rx_cfg1 = cfg_addr == ptp_corr_pkg::RX_CFG1_OFS;
  // Absent register decodes as unmapped: reads zero, writes dropped
  assign hit_tx_adj = PTP_EN && (cfg_addr == ptp_corr_pkg::TX_ADJ_OFS);
  assign hit_rxc = PCS_1000X && (mgmt_addr == ptp_corr_pkg::RXC_ADDR);
  assign hit_fixed = PCS_1000X && (mgmt_addr == ptp_corr_pkg::RX_FIXED_ADDR);
  assign hit_var = PCS_1000X && (mgmt_addr == ptp_corr_pkg::RX_VAR_ADDR);

  // ----------------------------------------
  // Next values
  // ----------------------------------------
  assign rx_cfg1_next = (cfg_wdata & ptp_corr_pkg::RX_CFG1_WMASK);
  assign tx_adj_next = (cfg_wdata & ptp_corr_pkg::TX_ADJ_WMASK);
  assign rxc_next = (mgmt_wdata & ptp_corr_pkg::RXC_WMASK);
  assign rx_fixed_next = mgmt_wdata;

  // ----------------------------------------
  // MAC configuration registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_cfg1_reg <= ptp_corr_pkg::RX_CFG1_RST;
      rx_inline_reg <= 1'b0;
      tx_adj_reg <= ptp_corr_pkg::TX_ADJ_RST;
    end
    else
    begin
      if (cfg_wr && hit_rx_cfg1)
      begin
        rx_cfg1_reg <= rx_cfg1_next;
        // No timestamp exists without support, so the enable stays low
        rx_inline_reg <= PTP_EN && cfg_wdata[ptp_corr_pkg::RX_INLINE_BIT];
      end
      if (cfg_wr && hit_tx_adj)
      begin
        tx_adj_reg <= tx_adj_next;
      end
    end
  end

  // ----------------------------------------
  // PCS management registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxc_reg <= ptp_corr_pkg::RXC_RST;
      rx_fixed_reg <= ptp_corr_pkg::RX_FIXED_RST;
    end
    else
    begin
      if (mgmt_wr && hit_rxc)
      begin
        rxc_reg <= rxc_next;
      end
      if (mgmt_wr && hit_fixed)
      begin
        rx_fixed_reg <= rx_fixed_next;
      end
    end
  end

  // ----------------------------------------
  // Variable latency capture
  // ----------------------------------------
  // Only the rising edge of lock samples the position, so the value
  // cannot drift mid-traffic if the barrel input wanders
  assign sync_rise = rx_sync_ok && !sync_q_reg;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_q_reg <= 1'b0;
      var_ui_reg <= 16'h0000;
    end
    else
    begin
      sync_q_reg <= rx_sync_ok;
      if (sync_rise)
      begin
        var_ui_reg <= barrel_pos;
      end
    end
  end

  // ----------------------------------------
  // Read paths
  // ----------------------------------------
  assign cfg_rmux = hit_rx_cfg1 ? rx_cfg1_reg : (hit_tx_adj ? tx_adj_reg : 32'h0000_0000);
  assign mgmt_rmux = hit_rxc ? rxc_reg :
                     hit_fixed ? rx_fixed_reg :
                     hit_var ? var_ui_reg : 16'h0000;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_rdata_reg <= 32'h0000_0000;
      cfg_rvalid_reg <= 1'b0;
      mgmt_rdata_reg <= 16'h0000;
      mgmt_rvalid_reg <= 1'b0;
    end
    else
    begin
      cfg_rvalid_reg <= cfg_rd;
      mgmt_rvalid_reg <= mgmt_rd;
      if (cfg_rd)
      begin
        cfg_rdata_reg <= cfg_rmux;
      end
      if (mgmt_rd)
      begin
        mgmt_rdata_reg <= mgmt_rmux;
      end
    end
  end

  // ----------------------------------------
  // Correction datapath
  // ----------------------------------------
  assign ctrl = '{
    tx_en: tx_adj_reg[ptp_corr_pkg::TX_CORR_EN_BIT],
    tx_lat_ns: tx_adj_reg[ptp_corr_pkg::TX_LAT_MSB:0],
    rx_master: PCS_1000X && rxc_reg[ptp_corr_pkg::RXC_MASTER_BIT],
    rx_fixed_en: rxc_reg[ptp_corr_pkg::RXC_FIXED_BIT],
    rx_var_en: rxc_reg[ptp_corr_pkg::RXC_VAR_BIT],
    rx_fixed_ns: rx_fixed_reg,
    rx_var_ui: var_ui_reg
  };

  ts_corrector u_corr
  (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ctrl(ctrl),
    .tx_in(tx_ts_in),
    .rx_in(rx_ts_in),
    .tx_out(tx_ts_out),
    .rx_out(rx_ts_out)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign cfg_rdata = cfg_rdata_reg;
  assign cfg_rvalid = cfg_rvalid_reg;
  assign mgmt_rdata = mgmt_rdata_reg;
  assign mgmt_rvalid = mgmt_rvalid_reg;
  assign rx_cfg_word = rx_cfg1_reg;
  assign pause_sa_hi = rx_cfg1_reg[ptp_corr_pkg::PAUSE_SA_MSB:0];
  assign rx_inline_ts_en = rx_inline_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_rx_cfg_write;
    cfg_wr && cfg_addr == ptp_corr_pkg::RX_CFG1_OFS;
  endsequence

  sequence s_sync_held;
    rx_sync_ok ##1 rx_sync_ok;
  endsequence

  sequence s_tx_adj_write;
    cfg_wr && cfg_addr == ptp_corr_pkg::TX_ADJ_OFS;
  endsequence

  sequence s_rxc_write;
    mgmt_wr && mgmt_addr == ptp_corr_pkg::RXC_ADDR;
  endsequence

  sequence s_var_write;
    mgmt_wr && mgmt_addr == ptp_corr_pkg::RX_VAR_ADDR;
  endsequence

  sequence s_var_read;
    mgmt_rd && mgmt_addr == ptp_corr_pkg::RX_VAR_ADDR;
  endsequence

  AST_RX_INLINE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_rx_cfg_write |=> rx_inline_ts_en == (PTP_EN && $past(cfg_wdata[22])))
    else $error("In-line timestamp enable does not follow bit 22");
  AST_NO_PTP_INLINE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !PTP_EN |-> !rx_inline_ts_en)
    else $error("In-line enable set in build without timestamping");
  AST_PAUSE_SA: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_rx_cfg_write ##1 !cfg_wr[*2] |-> pause_sa_hi == $past(cfg_wdata[15:0], 2))
    else $error("Pause address high bits not held");
  AST_TX_ABSENT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !PTP_EN && cfg_rd && cfg_addr == ptp_corr_pkg::TX_ADJ_OFS |=> cfg_rvalid && cfg_rdata == 32'h0000_0000)
    else $error("Absent adjust register read nonzero");
  AST_RXC_ABSENT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !PCS_1000X && mgmt_rd |=> mgmt_rvalid && mgmt_rdata == 16'h0000)
    else $error("PCS register read nonzero when not present");
  AST_VAR_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_sync_held |=> $stable(var_ui_reg))
    else $error("Variable latency changed during lock");
  AST_VAR_CAPTURE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rx_sync_ok && !sync_q_reg ##1 mgmt_rd && mgmt_addr == ptp_corr_pkg::RX_VAR_ADDR && rx_sync_ok
    |=> !PCS_1000X || mgmt_rdata == $past(barrel_pos, 2))
    else $error("Variable latency not captured at lock");
  AST_TX_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_tx_adj_write |=> !PTP_EN || tx_adj_reg == ($past(cfg_wdata) & ptp_corr_pkg::TX_ADJ_WMASK))
    else $error("Adjust register write not stored as masked");
  AST_RXC_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_rxc_write |=> !PCS_1000X || rxc_reg == ($past(mgmt_wdata) & ptp_corr_pkg::RXC_WMASK))
    else $error("Correction control write not stored as masked");
  AST_VAR_READONLY: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_var_write ##0 !sync_rise |=> $stable(var_ui_reg))
    else $error("Variable latency changed by a write");
  AST_VAR_READ: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_var_read |=> mgmt_rvalid && mgmt_rdata == (PCS_1000X ? $past(var_ui_reg) : 16'h0000))
    else $error("Variable latency read wrong");
  AST_INLINE_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !cfg_wr |=> $stable(rx_inline_ts_en))
    else $error("In-line enable moved without a write");
  AST_PAUSE_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !cfg_wr |=> $stable(pause_sa_hi))
    else $error("Pause address moved without a write");

endmodule // ptp_timestamp_correction_regs

//--- dv/tb_ptp_timestamp_correction_regs.sv
// Self-checking bench for the timestamp correction register block.
// Assumes single-cycle strobe ports; a reduced build shares the stimulus.
`timescale 1ns/1ns
module tb_ptp_timestamp_correction_regs;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  localparam logic [63:0] N_TS = 64'h0000_0001_0000_0000;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic [11:0] cfg_addr = 12'h000;
  logic [31:0] cfg_wdata = 32'h0000_0000;
  logic mgmt_wr = 1'b0;
  logic mgmt_rd = 1'b0;
  logic [4:0] mgmt_addr = 5'h00;
  logic [15:0] mgmt_wdata = 16'h0000;
  logic rx_sync_ok = 1'b0;
  logic [15:0] barrel_pos = 16'h0000;
  ptp_corr_pkg::ts_t tx_ts_in = '0;
  ptp_corr_pkg::ts_t rx_ts_in = '0;
  logic [31:0] cfg_rdata;
  logic [31:0] lite_cfg_rdata;
  logic [31:0] rx_cfg_word;
  logic [15:0] mgmt_rdata;
  logic [15:0] lite_mgmt_rdata;
  logic [15:0] pause_sa_hi;
  logic cfg_rvalid;
  logic mgmt_rvalid;
  logic rx_inline_ts_en;
  logic lite_inline;
  ptp_corr_pkg::ts_t tx_ts_out;
  ptp_corr_pkg::ts_t rx_ts_out;
  int fails = 0;
  int checks_done = 0;

  always #25 sys_clk = ~sys_clk;

  // ----------------------------------------
  // Full build and reduced build
  // ----------------------------------------
  ptp_timestamp_correction_regs i_dut
  (
    .sys_clk(sys_clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .mgmt_wr(mgmt_wr),
    .mgmt_rd(mgmt_rd), .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
    .mgmt_rvalid(mgmt_rvalid), .rx_sync_ok(rx_sync_ok), .barrel_pos(barrel_pos),
    .rx_cfg_word(rx_cfg_word), .pause_sa_hi(pause_sa_hi), .rx_inline_ts_en(rx_inline_ts_en),
    .tx_ts_in(tx_ts_in), .rx_ts_in(rx_ts_in), .tx_ts_out(tx_ts_out), .rx_ts_out(rx_ts_out)
  );

  // Options off: checks that the Tx adjust, Rx control and variable latency registers vanish
  ptp_timestamp_correction_regs #(.PTP_EN(1'b0), .PCS_1000X(1'b0)) i_dut_lite
  (
    .sys_clk(sys_clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(lite_cfg_rdata), .cfg_rvalid(), .mgmt_wr(mgmt_wr),
    .mgmt_rd(mgmt_rd), .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(lite_mgmt_rdata),
    .mgmt_rvalid(), .rx_sync_ok(rx_sync_ok), .barrel_pos(barrel_pos),
    .rx_cfg_word(), .pause_sa_hi(), .rx_inline_ts_en(lite_inline),
    .tx_ts_in(tx_ts_in), .rx_ts_in(rx_ts_in), .tx_ts_out(), .rx_ts_out()
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [64:0] seen, input logic [64:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask

  // Every access ends with an idle cycle so no strobe is set twice in one step
  task automatic cfg_write(input logic [11:0] a, input logic [31:0] d);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    tick(1);
    cfg_wr = 1'b0;
    tick(1);
  endtask

  task automatic cfg_read(input logic [11:0] a, output logic [64:0] got, output logic [64:0] lite);
    cfg_rd = 1'b1;
    cfg_addr = a;
    tick(1);
    cfg_rd = 1'b0;
    got = {cfg_rvalid, cfg_rdata};
    lite = lite_cfg_rdata;
    tick(1);
  endtask

  task automatic mgmt_write(input logic [4:0] a, input logic [15:0] d);
    mgmt_wr = 1'b1;
    mgmt_addr = a;
    mgmt_wdata = d;
    tick(1);
    mgmt_wr = 1'b0;
    tick(1);
  endtask

  task automatic mgmt_read(input logic [4:0] a, output logic [64:0] got, output logic [64:0] lite);
    mgmt_rd = 1'b1;
    mgmt_addr = a;
    tick(1);
    mgmt_rd = 1'b0;
    got = {mgmt_rvalid, mgmt_rdata};
    lite = lite_mgmt_rdata;
    tick(1);
  endtask

  task automatic ts_step(input logic [63:0] tx, input logic [63:0] rx);
    tx_ts_in = {1'b1, tx};
    rx_ts_in = {1'b1, rx};
    tick(1);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic sc_reset_values;
    logic [64:0] got;
    logic [64:0] lite;
    check(rx_cfg_word, 32'h1000_0000);
    check(pause_sa_hi, 16'h0000);
    check(rx_inline_ts_en, 1'b0);
    cfg_read(12'h41C, got, lite);
    check(got, {1'b1, 32'h0000_00D8});
    mgmt_read(5'h13, got, lite);
    check(got, {1'b1, 16'h000D});
    mgmt_read(5'h14, got, lite);
    check(got, {1'b1, 16'h00C8});
  endtask

  // All ones exposes reserved bits that wrongly store
  task automatic sc_rx_config;
    logic [64:0] got;
    logic [64:0] lite;
    cfg_write(12'h404, 32'hFFFF_FFFF);
    check(rx_cfg_word, 32'hFF40_FFFF);
    check(pause_sa_hi, 16'hFFFF);
    check(rx_inline_ts_en, 1'b1);
    check(lite_inline, 1'b0);
    cfg_read(12'h404, got, lite);
    check(got, {1'b1, 32'hFF40_FFFF});
    cfg_write(12'h404, 32'h1000_0000);
    check(rx_inline_ts_en, 1'b0);
  endtask

  task automatic sc_tx_adjust;
    logic [64:0] got;
    logic [64:0] lite;
    cfg_write(12'h41C, 32'hFFFF_FFFF);
    cfg_read(12'h41C, got, lite);
    check(got, {1'b1, 32'h0001_FFFF});
    check(lite, 32'h0000_0000);
    ts_step(N_TS, N_TS);
    check(tx_ts_out, {1'b1, N_TS + 64'h0000_0000_0000_FFFF});
    cfg_write(12'h41C, 32'h0000_FFFF);
    ts_step(N_TS, N_TS);
    check(tx_ts_out, {1'b1, N_TS});
    cfg_read(12'h400, got, lite);
    check(got, {1'b1, 32'h0000_0000});
  endtask

  // Fixed 100 ns, variable 10 UI which is 8 ns
  task automatic sc_rx_correction;
    logic [64:0] got;
    logic [64:0] lite;
    logic [15:0] ctl [4] = '{16'h000D, 16'h0009, 16'h000C, 16'h0005};
    logic [63:0] sub [4] = '{64'h6C, 64'h08, 64'h64, 64'h00};
    mgmt_write(5'h14, 16'h0064);
    rx_sync_ok = 1'b1;
    barrel_pos = 16'h000A;
    tick(1);
    barrel_pos = 16'h0014;
    tick(2);
    mgmt_read(5'h15, got, lite);
    check(got, {1'b1, 16'h000A});
    check(lite, 16'h0000);
    mgmt_write(5'h15, 16'h1234);
    mgmt_read(5'h15, got, lite);
    check(got, {1'b1, 16'h000A});
    mgmt_write(5'h13, 16'hFFFF);
    mgmt_read(5'h13, got, lite);
    check(got, {1'b1, 16'h000D});
    check(lite, 16'h0000);
    mgmt_read(5'h14, got, lite);
    check(got, {1'b1, 16'h0064});
    for (int i = 0; i < 4; i++)
    begin
      mgmt_write(5'h13, ctl[i]);
      ts_step(N_TS, N_TS);
      check(rx_ts_out, {1'b1, N_TS - sub[i]});
    end
    rx_sync_ok = 1'b0;
    tick(2);
    rx_sync_ok = 1'b1;
    barrel_pos = 16'h000F;
    // Read right after lock so the capture is seen at once
    tick(1);
    mgmt_read(5'h15, got, lite);
    check(got, {1'b1, 16'h000F});
  endtask

  // ----------------------------------------
  // Verdict
  // ----------------------------------------
  task automatic final_report;
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Guards against a hang anywhere in the sequence
  initial
  begin
    #2000000;
    fails++;
    final_report();
  end

  initial
  begin
    tick(3);
    rst_n = 1'b1;
    sc_reset_values();
    sc_rx_config();
    sc_tx_adjust();
    sc_rx_correction();
    final_report();
  end
endmodule // tb_ptp_timestamp_correction_regs
